// *** verification/pause_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
// port-level checks of bus answers and pause requests
module pause_asserts
  import pause_pkg::*;
#(
  parameter int fill_w = 18
)(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // direction
  input wire logic [15:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic [fill_w-1:0] rx_fill, // fullness
  input wire logic tx_accept, // frame taken
  input wire logic tx_valid, // frame pending
  input wire logic tx_xoff, // frame kind
  input wire logic [15:0] tx_timer // frame timer
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic mapped; // address hits a register
  assign mapped = paddr inside {threshold_off, status_off, control_off,
    watermark_off, timer_off};
  ////////////////////////////////////////////////////////////////////////
  sequence s_setup;
    psel && !penable;
  endsequence
  a_ready_next: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_status_spare: assert property (
    pready && !pwrite && paddr == status_off |-> prdata[15:3] == 13'h0)
    else $error("status spare bits set");
  a_xon_timer: assert property (
    tx_valid && !tx_xoff |-> tx_timer == 16'h0)
    else $error("resume frame with timer");
  a_pause_holds: assert property (
    tx_valid && !tx_accept |=> tx_valid)
    else $error("pause request dropped");
endmodule : pause_asserts
`default_nettype wire

// *** verification/pause_partner.sv ***
`timescale 1ns/100ps
`default_nettype none
// link partner side: takes pause frames after a set lag, counts them
module pause_partner
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic tx_valid, // frame pending
  input wire logic tx_xoff, // frame kind
  input wire logic [15:0] tx_timer, // frame timer
  input wire logic [3:0] lag, // cycles before taking
  output logic tx_accept, // frame taken
  output int n_xoff, // pause frames seen
  output int n_xon, // resume frames seen
  output logic [15:0] last_timer // timer of last frame
);
  logic [3:0] wait_r; // cycles waited on this frame
  // take after lag, record the frame at the taking edge
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      tx_accept <= 1'b0;
      wait_r <= 4'h0;
      n_xoff <= 0;
      n_xon <= 0;
      last_timer <= 16'h0;
    end
    else
    begin
      tx_accept <= tx_valid && !tx_accept && wait_r >= lag;
      wait_r <= (tx_valid && !tx_accept && wait_r < lag) ?
                wait_r + 4'h1 : 4'h0;
      if (tx_valid && tx_accept)
      begin
        n_xoff <= n_xoff + (tx_xoff ? 1 : 0);
        n_xon <= n_xon + (tx_xoff ? 0 : 1);
        last_timer <= tx_timer;
      end
    end
endmodule : pause_partner
`default_nettype wire

// *** verification/tb_pause_refresh_and_status.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_pause_refresh_and_status
  import pause_pkg::*;
;
  logic pclk = 1'b0; // bus clock
  logic presetn = 1'b0; // reset
  logic psel = 1'b0; // apb request
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata; // apb answer
  logic pready;
  logic pslverr;
  logic [17:0] rx_fill = 18'h0; // buffer fullness
  logic tx_accept; // pause link
  logic tx_valid;
  logic tx_xoff;
  logic [15:0] tx_timer;
  logic [3:0] lag = 4'h0; // partner delay
  int n_xoff; // partner counts
  int n_xon;
  logic [15:0] last_timer;
  logic [31:0] rq; // last read data
  logic re; // last error flag
  int bad_count = 0;
  int samples_checked = 0;
  int x0; // saved count
  always #2 pclk = ~pclk;
  pause_refresh_and_status #(.fill_w(18)) i_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_fill(rx_fill), .tx_accept(tx_accept),
    .tx_valid(tx_valid), .tx_xoff(tx_xoff), .tx_timer(tx_timer));
  pause_partner i_peer (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid),
    .tx_xoff(tx_xoff), .tx_timer(tx_timer), .lag(lag),
    .tx_accept(tx_accept), .n_xoff(n_xoff), .n_xon(n_xon),
    .last_timer(last_timer));
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done
  // compare and report
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // one apb transfer, answer kept in rq and re
  task automatic apb(input logic w, input logic [15:0] a,
    input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, pready, 1'b1);
      bad_count++;
      test_done;
    end
    @(posedge pclk);
  endtask : apb
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, threshold_off, 32'h0000abcd);
    apb(1'b0, threshold_off, 32'h0);
    chk(rq, 32'h0000abcd);
    apb(1'b0, 16'h2474, 32'h0);
    chk(32'(re), 32'h1);
    apb(1'b1, 16'h2474, 32'h0);
    chk(32'(re), 32'h1);
    apb(1'b1, watermark_off, 32'h00040002);
    apb(1'b1, timer_off, 32'h00001234);
    apb(1'b1, threshold_off, 32'h0);
    apb(1'b1, control_off, 32'h3);
    apb(1'b0, control_off, 32'h0);
    chk(rq, 32'h3);
    apb(1'b0, watermark_off, 32'h0);
    chk(rq, 32'h00040002);
    apb(1'b0, timer_off, 32'h0);
    chk(rq, 32'h00001234);
    apb(1'b1, status_off, 32'hffffffff);
    apb(1'b0, status_off, 32'h0);
    chk(rq, 32'h4);
    rx_fill <= 18'd80;
    repeat (10) @(posedge pclk);
    chk(32'(n_xoff), 32'h1);
    chk(32'(last_timer), 32'h1234);
    apb(1'b0, status_off, 32'h0);
    chk(rq & 32'hffff, 32'h3);
    repeat (100) @(posedge pclk);
    chk(32'(n_xoff), 32'h1);
    lag <= 4'h5;
    apb(1'b1, threshold_off, 32'd20);
    x0 = n_xoff;
    repeat (100) @(posedge pclk);
    chk(32'(n_xoff - x0 >= 4 && n_xoff - x0 <= 6), 32'h1);
    apb(1'b0, status_off, 32'h0);
    chk(32'(rq[31:16] <= 16'd21 && rq[0]), 32'h1);
    rx_fill <= 18'd16;
    repeat (20) @(posedge pclk);
    chk(32'(n_xon), 32'h1);
    chk(32'(last_timer), 32'h0);
    apb(1'b0, status_off, 32'h0);
    chk(rq, 32'h4);
    apb(1'b1, threshold_off, 32'h0);
    apb(1'b1, control_off, 32'h1);
    rx_fill <= 18'd80;
    repeat (20) @(posedge pclk);
    rx_fill <= 18'd16;
    repeat (20) @(posedge pclk);
    chk(32'(n_xon), 32'h1);
    apb(1'b1, control_off, 32'h0);
    x0 = n_xoff;
    rx_fill <= 18'd80;
    repeat (20) @(posedge pclk);
    chk(32'(n_xoff - x0), 32'h0);
    apb(1'b1, control_off, 32'h1);
    repeat (4) @(posedge pclk);
    chk(32'(tx_valid), 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, status_off, 32'h0);
    chk(rq, 32'h4);
    apb(1'b0, status_off, 32'h0);
    chk(rq, 32'h2);
    apb(1'b0, watermark_off, 32'h0);
    chk(rq, 32'h0);
    chk(32'(tx_valid), 32'h0);
    test_done;
  end
endmodule : tb_pause_refresh_and_status
bind pause_refresh_and_status pause_asserts #(.fill_w(fill_w)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_fill(rx_fill),
  .tx_accept(tx_accept), .tx_valid(tx_valid), .tx_xoff(tx_xoff),
  .tx_timer(tx_timer));
`default_nettype wire

// *** verilog/mark_compare.sv ***
`timescale 1ns/100ps
`default_nettype none
// compares buffer fullness (bytes) against one watermark (16-byte units)
module mark_compare
  import pause_pkg::*;
#(
  parameter int fill_w = 18
)(
  input wire logic [fill_w-1:0] fill, // buffer fullness in bytes
  input wire logic [mark_w-1:0] mark, // watermark in 16-byte units
  output logic ge, // fullness at or above mark
  output logic gt // fullness strictly above mark
);

  logic [fill_w+3:0] fill_x; // widened fullness
  logic [fill_w+3:0] mark_x; // watermark in bytes

  // scale and compare
  always_comb
  begin
    fill_x = {4'h0, fill};
    mark_x = {{(fill_w - mark_w + 4){1'b0}}, mark} << 4;
    ge = fill_x >= mark_x;
    gt = fill_x > mark_x;
  end

endmodule : mark_compare
`default_nettype wire

// *** verilog/pause_pkg.sv ***
// How it works
// - sixteen-bit refresh threshold, used when transmit pause enabled
// - counter hits threshold while paused: resend XOFF
// - zero threshold disables periodic XOFF refresh
// - status bit 0 shows XON/XOFF, resets XON
// - status bit 1 set above high watermark
// - status bit 2 set below low watermark, resets one
// - status bits 31:16 show refresh counter
// - fullness at or above high watermark sends XOFF
// - falling to low watermark sends XON if enabled
// - XOFF frame carries sixteen-bit pause timer value
package pause_pkg;

  // register byte offsets
  localparam logic [15:0] threshold_off = 16'h2460;
  localparam logic [15:0] status_off = 16'h2464;
  localparam logic [15:0] control_off = 16'h2468;
  localparam logic [15:0] watermark_off = 16'h246c;
  localparam logic [15:0] timer_off = 16'h2470;

  // control register fields
  localparam int tx_pause_enable_bit = 0;
  localparam int resume_frame_enable_bit = 1;

  // status register fields
  localparam int state_bit = 0;
  localparam int above_high_bit = 1;
  localparam int below_low_bit = 2;
  localparam int counter_lsb = 16;

  // watermark register fields, 16-byte units
  localparam int low_lsb = 0;
  localparam int high_lsb = 16;
  localparam int mark_w = 14;

  // reset values
  localparam logic [15:0] threshold_rst = 16'h0000;
  localparam logic [15:0] timer_rst = 16'h0000;
  localparam logic [1:0] control_rst = 2'h0;
  localparam logic [13:0] mark_rst = 14'h0000;
  localparam logic below_low_rst = 1'b1;

  // flow control state
  typedef enum logic [1:0] {
    st_xon = 2'b01,
    st_xoff = 2'b10
  } pause_state_t;

  // pause frame request toward the transmitter
  typedef struct packed {
    logic valid;
    logic xoff;
    logic [15:0] timer;
  } pause_req_t;

endpackage : pause_pkg

// *** verilog/pause_refresh_and_status.sv ***
`timescale 1ns/100ps
`default_nettype none
// receive-side pause control with XOFF refresh and status word
module pause_refresh_and_status
  import pause_pkg::*;
#(
  parameter int fill_w = 18
)(
  input wire logic pclk, // bus clock
  input wire logic presetn, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [15:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic [fill_w-1:0] rx_fill, // receive buffer bytes held
  input wire logic tx_accept, // transmitter took pause request
  output logic tx_valid, // pause frame request pending
  output logic tx_xoff, // 1 XOFF, 0 XON
  output logic [15:0] tx_timer // timer field of frame
);

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic [15:0] refresh_threshold_r; // refresh threshold
  logic [15:0] pause_timer_value_r; // pause time in slots
  logic tx_pause_enable_r; // transmit pause enable
  logic resume_frame_enable_r; // XON frames enable
  logic [mark_w-1:0] low_watermark_r; // low watermark
  logic [mark_w-1:0] high_watermark_r; // high watermark
  pause_state_t state_r; // flow control state
  logic above_high_r; // fullness above high mark
  logic below_low_r; // fullness below low mark
  logic [15:0] refresh_cnt_r; // shadow refresh counter
  pause_req_t req_r; // pending frame request
  logic pready_r; // one-cycle ready
  logic [31:0] prdata_r; // read data
  logic pslverr_r; // error answer

  logic high_ge; // fill >= high
  logic high_gt; // fill > high
  logic low_ge; // fill >= low
  logic low_gt; // fill > low
  logic wr_go; // write takes effect
  logic rd_go; // read completes
  logic mapped; // address decodes
  logic send_xoff; // first XOFF event
  logic send_refresh; // refresh XOFF event
  logic send_xon; // XON event

  ////////////////////////////////////////////////////////////////////////
  // watermark compares

  mark_compare #(.fill_w(fill_w)) u_high (
    .fill(rx_fill),
    .mark(high_watermark_r),
    .ge(high_ge),
    .gt(high_gt)
  );

  mark_compare #(.fill_w(fill_w)) u_low (
    .fill(rx_fill),
    .mark(low_watermark_r),
    .ge(low_ge),
    .gt(low_gt)
  );

  ////////////////////////////////////////////////////////////////////////
  // apb decode; ready answers in the first access cycle

  always_comb
  begin
    mapped = (paddr == threshold_off) || (paddr == status_off) ||
             (paddr == control_off) || (paddr == watermark_off) ||
             (paddr == timer_off);
    wr_go = psel && penable && pready_r && pwrite && mapped;
    rd_go = psel && penable && pready_r && !pwrite;
  end

  // ready pulse: high for the cycle after setup
  // every access therefore takes exactly one access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
    end
    else
    begin
      pready_r <= psel && !penable;
    end
  end

  // error for unmapped addresses
  // pslverr rides with pready, so the master sees both at the same edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr_r <= 1'b0;
    end
    else
    begin
      pslverr_r <= psel && !penable && !mapped;
    end
  end

  // read mux, reserved bits read zero
  // data is captured at setup so it stands through the access cycle,
  // and is cleared afterwards so a stale word never lingers on the bus
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h0000_0000;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata_r <= 32'h0000_0000;
      case (paddr)
        threshold_off: prdata_r[15:0] <= refresh_threshold_r;
        status_off:
        begin
          prdata_r[state_bit] <= (state_r == st_xoff);
          prdata_r[above_high_bit] <= above_high_r;
          prdata_r[below_low_bit] <= below_low_r;
          prdata_r[counter_lsb +: 16] <= refresh_cnt_r;
        end
        control_off:
        begin
          prdata_r[tx_pause_enable_bit] <= tx_pause_enable_r;
          prdata_r[resume_frame_enable_bit] <= resume_frame_enable_r;
        end
        watermark_off:
        begin
          prdata_r[low_lsb +: mark_w] <= low_watermark_r;
          prdata_r[high_lsb +: mark_w] <= high_watermark_r;
        end
        timer_off: prdata_r[15:0] <= pause_timer_value_r;
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
    else if (rd_go)
    begin
      prdata_r <= 32'h0000_0000; // read done, drop the word
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers; status offset is not writable
  // writes land at the access edge only; unmapped and status offsets
  // leave every register untouched

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      refresh_threshold_r <= threshold_rst;
      pause_timer_value_r <= timer_rst;
      tx_pause_enable_r <= control_rst[tx_pause_enable_bit];
      resume_frame_enable_r <= control_rst[resume_frame_enable_bit];
      low_watermark_r <= mark_rst;
      high_watermark_r <= mark_rst;
    end
    else if (wr_go)
    begin
      case (paddr)
        threshold_off: refresh_threshold_r <= pwdata[15:0];
        control_off:
        begin
          tx_pause_enable_r <= pwdata[tx_pause_enable_bit];
          resume_frame_enable_r <= pwdata[resume_frame_enable_bit];
        end
        watermark_off:
        begin
          low_watermark_r <= pwdata[low_lsb +: mark_w];
          high_watermark_r <= pwdata[high_lsb +: mark_w];
        end
        timer_off: pause_timer_value_r <= pwdata[15:0];
        default: ; // status write ignored
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fullness flags
  // registered from the compares, so they trail rx_fill by one cycle;
  // below-low comes out of reset set, as the buffer starts empty

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      above_high_r <= 1'b0;
      below_low_r <= below_low_rst;
    end
    else
    begin
      above_high_r <= high_gt;
      below_low_r <= !low_ge;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flow control events
  // leaving XOFF needs no enable term; only the frame depends on the
  // enable bits
  // refresh needs fullness still above the low mark, so a draining
  // buffer never gets a fresh pause just before the resume

  always_comb
  begin
    send_xoff = tx_pause_enable_r && (state_r == st_xon) && high_ge;
    send_refresh = tx_pause_enable_r && (state_r == st_xoff) && low_gt &&
                   (refresh_threshold_r != 16'h0000) &&
                   (refresh_cnt_r >= refresh_threshold_r);
    send_xon = (state_r == st_xoff) && !low_gt;
  end

  // xon/xoff state machine
  // clearing the transmit pause enable drops back to XON without a frame,
  // so a disabled port cannot stay stuck in the pause state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= st_xon;
    end
    else
    begin
      case (state_r)
        st_xon: if (send_xoff) state_r <= st_xoff;
        st_xoff: if (send_xon || !tx_pause_enable_r) state_r <= st_xon;
        default: state_r <= st_xon;
      endcase
    end
  end

  // shadow refresh counter
  // counts cycles spent in XOFF and saturates instead of wrapping, so a
  // late threshold write still triggers a refresh at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      refresh_cnt_r <= 16'h0000;
    end
    else if (state_r != st_xoff || send_xon || !tx_pause_enable_r)
    begin
      refresh_cnt_r <= 16'h0000;
    end
    else if (send_refresh)
    begin
      refresh_cnt_r <= 16'h0000;
    end
    else if (refresh_cnt_r != 16'hffff)
    begin
      refresh_cnt_r <= refresh_cnt_r + 16'h0001;
    end
  end

  // frame request; newest event replaces any unsent one
  // the partner only needs the latest pause state, never a backlog;
  // an XON event with transmit pause enabled and resume frames disabled cancels a waiting XOFF,
  // and an event in the same cycle as tx_accept wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_r <= '0;
    end
    else if (send_xoff || send_refresh)
    begin
      req_r.valid <= 1'b1;
      req_r.xoff <= 1'b1;
      req_r.timer <= pause_timer_value_r;
    end
    else if (send_xon && tx_pause_enable_r)
    begin
      req_r.valid <= resume_frame_enable_r;
      req_r.xoff <= 1'b0;
      req_r.timer <= 16'h0000;
    end
    else if (tx_accept)
    begin
      req_r.valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  // plain copies of flip-flops, no logic after the registers

  always_comb
  begin
    prdata = prdata_r;
    pready = pready_r;
    pslverr = pslverr_r;
    tx_valid = req_r.valid;
    tx_xoff = req_r.xoff;
    tx_timer = req_r.timer;
  end

endmodule : pause_refresh_and_status
`default_nettype wire
